// ### inc/rx_alarm_defs.svh
`ifndef RX_ALARM_DEFS_SVH
`define RX_ALARM_DEFS_SVH

// register word indices (printed offsets kept as indices, byte address = 4 * index)
`define IDX_FAR_END_CODE     9'h016
`define IDX_CODE_IRQ_CTRL    9'h017
`define IDX_LINK_CTRL        9'h018
`define IDX_MSG_BUF_FIRST    9'h0DE
`define IDX_MSG_BUF_LAST     9'h135
`define MSG_BUF_DEPTH        88
`define MSG_PTR_W            7

// code irq ctrl fields
`define CODE_VALID_FLAG_BIT  0
`define CODE_VALID_EN_BIT    1
`define CODE_RM_FLAG_BIT     2
`define CODE_RM_EN_BIT       3
`define CODE_VALID_ST_BIT    4

// link ctrl fields
`define LINK_FLAG_BIT        0
`define LINK_IRQ_EN_BIT      1
`define LINK_EN_BIT          2

// code window: history depth and vote thresholds
`define CODE_HIST_LEN        10
`define CODE_VALID_VOTES     4'h8
`define CODE_REMOVE_VOTES    4'h3
`define CODE_W               6

`endif

// ### inc/rx_alarm_pkg.sv
package rx_alarm_pkg;
    // code validator state
    typedef enum logic [1:0] {
        CODE_IDLE  = 2'b01,
        CODE_VALID = 2'b10
    } code_state_t;
endpackage

// ### src/code_vote_window.sv
`include "rx_alarm_defs.svh"

// keeps the last ten received codes and counts how many match a candidate
module code_vote_window
    import rx_alarm_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    // incoming code strobe
    input  wire logic                   code_stb_i,
    input  wire logic [`CODE_W-1:0]     code_i,
    // comparison
    input  wire logic [`CODE_W-1:0]     ref_i,
    output logic      [3:0]             new_votes_o,
    output logic      [3:0]             diff_votes_o
);
    logic [`CODE_W-1:0] hist_ff     [`CODE_HIST_LEN];
    logic [`CODE_W-1:0] nxt_hist    [`CODE_HIST_LEN];
    logic [`CODE_HIST_LEN-1:0] fill_ff;
    logic [`CODE_HIST_LEN-1:0] nxt_fill;

    // shift in a new code; the window counts only receptions actually seen
    always_comb begin
        nxt_fill = fill_ff;
        for (int i = 0; i < `CODE_HIST_LEN; i++) begin
            nxt_hist[i] = hist_ff[i];
        end
        if (code_stb_i) begin
            nxt_hist[0] = code_i;
            nxt_fill    = {fill_ff[`CODE_HIST_LEN-2:0], 1'b1};
            for (int i = 1; i < `CODE_HIST_LEN; i++) begin
                nxt_hist[i] = hist_ff[i-1];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fill_ff <= '0;
            for (int i = 0; i < `CODE_HIST_LEN; i++) begin
                hist_ff[i] <= '0;
            end
        end else begin
            fill_ff <= nxt_fill;
            for (int i = 0; i < `CODE_HIST_LEN; i++) begin
                hist_ff[i] <= nxt_hist[i];
            end
        end
    end

    // votes over the window including the code arriving this cycle
    always_comb begin
        new_votes_o  = 4'h0;
        diff_votes_o = 4'h0;
        for (int i = 0; i < `CODE_HIST_LEN; i++) begin
            if (nxt_fill[i] && nxt_hist[i] == nxt_hist[0]) begin
                new_votes_o = new_votes_o + 4'h1;
            end
            if (nxt_fill[i] && nxt_hist[i] != ref_i) begin
                diff_votes_o = diff_votes_o + 4'h1;
            end
        end
    end
endmodule

// ### src/rx_alarm_msg_interrupts.sv
// Functional notes
// - any of the three raised interrupts drives the active-low request output low
// - code removal sets status bit 2 of register 0x17 (here set only while the removal enable, bit 3, is on)
// - code removal clears the six-bit code field at 0x16
// - completed link message raises the message interrupt when enabled
// - message interrupt enable is bit 1 of register 0x18
// - message interrupt sets status bit 0 of register 0x18
// - new link messages are stored in the buffer at 0xDE to 0x135
// - code removed when a different code appears 3 of last 10
// - code validated after 8 of last 10 equal, loaded into 0x16
// - removal interrupt enable is bit 3 of register 0x17
//
// The APB interface to the registers is this design's own decision.
`include "rx_alarm_defs.svh"

module rx_alarm_msg_interrupts
    import rx_alarm_pkg::*;
(
    // clock and reset
    input  wire logic                   MCLK_I,
    input  wire logic                   ARST_N_I,
    // apb slave
    input  wire logic                   PSEL_I,
    input  wire logic                   PENABLE_I,
    input  wire logic                   PWRITE_I,
    input  wire logic [11:0]            PADDR_I,
    input  wire logic [31:0]            PWDATA_I,
    output logic      [31:0]            PRDATA_O,
    output logic                        PREADY_O,
    output logic                        PSLVERR_O,
    // received far-end codes
    input  wire logic                   CODE_STB_I,
    input  wire logic [`CODE_W-1:0]     CODE_I,
    // receive hdlc controller message bytes
    input  wire logic                   MSG_BYTE_STB_I,
    input  wire logic [7:0]             MSG_BYTE_I,
    input  wire logic                   MSG_END_I,
    // interrupt request, active low
    output logic                        INT_N_O,
    // link receiver enable to the hdlc controller
    output logic                        RX_LINK_MSG_EN_O
);
    code_state_t        state_ff,  nxt_state;
    logic [`CODE_W-1:0] code_ff,   nxt_code;
    logic               code_valid_flag_ff,   nxt_code_valid_flag;
    logic               code_valid_irq_en_ff, nxt_code_valid_irq_en;
    logic               code_removed_flag_ff,   nxt_code_removed_flag;
    logic               code_removed_irq_en_ff, nxt_code_removed_irq_en;
    logic               rx_link_msg_flag_ff,   nxt_rx_link_msg_flag;
    logic               rx_link_msg_irq_en_ff, nxt_rx_link_msg_irq_en;
    logic               rx_link_msg_en_ff,     nxt_rx_link_msg_en;
    logic [7:0]         msg_buf   [`MSG_BUF_DEPTH];
    logic [`MSG_PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr;
    logic [31:0]        rdata_ff,  nxt_rdata;
    logic [3:0]         new_votes;
    logic [3:0]         diff_votes;
    logic               validate_evt;
    logic               remove_evt;
    logic               msg_done_evt;
    logic               apb_acc;
    logic               apb_wr;
    logic               apb_rd;
    logic               apb_setup;
    logic               msg_wr_en;
    logic [8:0]         reg_idx;
    logic [31:0]        code_ctrl_word;
    logic [31:0]        link_ctrl_word;

    // register map, word index = byte address / 4:
    //   far-end code:   bits 5..0 the validated code, zero while none stands
    //   code irq ctrl:  b0 valid flag, b1 valid enable, b2 removed flag,
    //                   b3 removed enable, b4 a validated code stands
    //   link ctrl:      b0 message flag, b1 message irq enable, b2 receiver enable
    //   message buffer: one byte per word, byte k of the last message at index k
    // flags clear on read, enables are read/write, everything else reads zero,
    // ignores writes and never signals an error

    // decode a word address into a register index; bit 11 and the byte lane
    // bits are not decoded, so those aliases land on the same word
    function automatic logic [8:0] word_idx(input logic [11:0] addr);
        return addr[10:2];
    endfunction

    // true when the index falls inside the message buffer window
    // both ends of the window are inclusive
    function automatic logic in_msg_buf(input logic [8:0] idx);
        return (idx >= `IDX_MSG_BUF_FIRST) && (idx <= `IDX_MSG_BUF_LAST);
    endfunction

    // ten-deep history of received codes; both vote counts include the code
    // strobed this cycle, so a decision lands on the same edge as its code
    code_vote_window u_votes (
        .clk_i        (MCLK_I),
        .arst_n_i     (ARST_N_I),
        .code_stb_i   (CODE_STB_I),
        .code_i       (CODE_I),
        .ref_i        (code_ff),
        .new_votes_o  (new_votes),
        .diff_votes_o (diff_votes)
    );

    // apb: zero wait states. read data is registered at the setup edge, so it
    // already stands from a flop in the access cycle where the master takes it;
    // the flag clear waits for the access edge
    assign apb_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign apb_acc   = PSEL_I && PENABLE_I;
    assign apb_wr    = apb_acc && PWRITE_I;
    assign apb_rd    = apb_acc && !PWRITE_I;
    assign reg_idx   = word_idx(PADDR_I);
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = 1'b0;
    assign PRDATA_O  = rdata_ff;

    // code events from the vote window; only one of them is looked at in a
    // given state, so validation and removal never fire together
    assign validate_evt = CODE_STB_I && (state_ff == CODE_IDLE)
                          && (new_votes >= `CODE_VALID_VOTES);
    assign remove_evt   = CODE_STB_I && (state_ff == CODE_VALID)
                          && (diff_votes >= `CODE_REMOVE_VOTES);
    assign msg_done_evt = MSG_END_I && rx_link_msg_en_ff;
    // bytes and message ends are dropped while the receiver is disabled
    assign msg_wr_en    = MSG_BYTE_STB_I && rx_link_msg_en_ff;

    // validator state and received code register
    // removal zeroes the code so software never reads back a stale code;
    // a code is loaded only on validation, never on a plain strobe
    always_comb begin
        nxt_state = state_ff;
        nxt_code  = code_ff;
        case (state_ff)
            CODE_IDLE: begin
                if (validate_evt) begin
                    nxt_state = CODE_VALID;
                    nxt_code  = CODE_I;
                end
            end
            CODE_VALID: begin
                if (remove_evt) begin
                    nxt_state = CODE_IDLE;
                    nxt_code  = '0;
                end
            end
            default: begin
                nxt_state = CODE_IDLE;
            end
        endcase
    end

    // validator registers
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff <= CODE_IDLE;
            code_ff  <= '0;
        end else begin
            state_ff <= nxt_state;
            code_ff  <= nxt_code;
        end
    end

    // enables and sticky flags; a set in the read cycle beats the clear, and a
    // read clears only what its data reported, so an event that lands between
    // the setup and access edges survives until the next read
    always_comb begin
        logic rd17;
        logic rd18;
        rd17 = apb_rd && (reg_idx == `IDX_CODE_IRQ_CTRL);
        rd18 = apb_rd && (reg_idx == `IDX_LINK_CTRL);
        nxt_code_valid_irq_en   = code_valid_irq_en_ff;
        nxt_code_removed_irq_en = code_removed_irq_en_ff;
        nxt_rx_link_msg_irq_en  = rx_link_msg_irq_en_ff;
        nxt_rx_link_msg_en      = rx_link_msg_en_ff;
        if (apb_wr && reg_idx == `IDX_CODE_IRQ_CTRL) begin
            nxt_code_valid_irq_en   = PWDATA_I[`CODE_VALID_EN_BIT];
            nxt_code_removed_irq_en = PWDATA_I[`CODE_RM_EN_BIT];
        end else if (apb_wr && reg_idx == `IDX_LINK_CTRL) begin
            nxt_rx_link_msg_irq_en  = PWDATA_I[`LINK_IRQ_EN_BIT];
            nxt_rx_link_msg_en      = PWDATA_I[`LINK_EN_BIT];
        end
        nxt_code_valid_flag   = code_valid_flag_ff
                                && !(rd17 && rdata_ff[`CODE_VALID_FLAG_BIT]);
        nxt_code_removed_flag = code_removed_flag_ff
                                && !(rd17 && rdata_ff[`CODE_RM_FLAG_BIT]);
        nxt_rx_link_msg_flag  = rx_link_msg_flag_ff
                                && !(rd18 && rdata_ff[`LINK_FLAG_BIT]);
        if (validate_evt && code_valid_irq_en_ff) begin
            nxt_code_valid_flag = 1'b1;
        end
        if (remove_evt && code_removed_irq_en_ff) begin
            nxt_code_removed_flag = 1'b1;
        end
        if (msg_done_evt && rx_link_msg_irq_en_ff) begin
            nxt_rx_link_msg_flag = 1'b1;
        end
    end

    // everything comes up disabled, so nothing interrupts until software opts in
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            code_valid_flag_ff     <= 1'b0;
            code_valid_irq_en_ff   <= 1'b0;
            code_removed_flag_ff   <= 1'b0;
            code_removed_irq_en_ff <= 1'b0;
            rx_link_msg_flag_ff    <= 1'b0;
            rx_link_msg_irq_en_ff  <= 1'b0;
            rx_link_msg_en_ff      <= 1'b0;
        end else begin
            code_valid_flag_ff     <= nxt_code_valid_flag;
            code_valid_irq_en_ff   <= nxt_code_valid_irq_en;
            code_removed_flag_ff   <= nxt_code_removed_flag;
            code_removed_irq_en_ff <= nxt_code_removed_irq_en;
            rx_link_msg_flag_ff    <= nxt_rx_link_msg_flag;
            rx_link_msg_irq_en_ff  <= nxt_rx_link_msg_irq_en;
            rx_link_msg_en_ff      <= nxt_rx_link_msg_en;
        end
    end

    // request is low while any enabled flag stands
    // decoded from flops only, so bus activity cannot glitch the pin;
    // the pin drops one edge after the event that sets the flag
    assign INT_N_O = !((code_valid_flag_ff && code_valid_irq_en_ff)
                     || (code_removed_flag_ff && code_removed_irq_en_ff)
                     || (rx_link_msg_flag_ff && rx_link_msg_irq_en_ff));
    assign RX_LINK_MSG_EN_O = rx_link_msg_en_ff;

    // message write pointer; restarts at the buffer base after each message
    // a byte and an end in one cycle: the byte is stored, then the pointer restarts
    always_comb begin
        nxt_wr_ptr = wr_ptr_ff;
        if (msg_done_evt) begin
            nxt_wr_ptr = '0;
        end else if (msg_wr_en
                     && wr_ptr_ff != `MSG_PTR_W'(`MSG_BUF_DEPTH - 1)) begin
            nxt_wr_ptr = wr_ptr_ff + `MSG_PTR_W'(1);  // overlong message keeps last slot
        end
    end

    // pointer register
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
        end
    end

    // buffer storage has no reset, which keeps it a plain ram; contents are
    // valid only after a message, and only the bytes it stored
    always_ff @(posedge MCLK_I) begin
        if (msg_wr_en) begin
            msg_buf[wr_ptr_ff] <= MSG_BYTE_I;
        end
    end

    // status word as the host sees it; unused upper bits read zero
    always_comb begin
        code_ctrl_word = 32'h0;
        code_ctrl_word[`CODE_VALID_FLAG_BIT] = code_valid_flag_ff;
        code_ctrl_word[`CODE_VALID_EN_BIT]   = code_valid_irq_en_ff;
        code_ctrl_word[`CODE_RM_FLAG_BIT]    = code_removed_flag_ff;
        code_ctrl_word[`CODE_RM_EN_BIT]      = code_removed_irq_en_ff;
        code_ctrl_word[`CODE_VALID_ST_BIT]   = (state_ff == CODE_VALID);
    end

    // link control word
    always_comb begin
        link_ctrl_word = 32'h0;
        link_ctrl_word[`LINK_FLAG_BIT]   = rx_link_msg_flag_ff;
        link_ctrl_word[`LINK_IRQ_EN_BIT] = rx_link_msg_irq_en_ff;
        link_ctrl_word[`LINK_EN_BIT]     = rx_link_msg_en_ff;
    end

    // read data, captured at the setup edge and held through the access cycle;
    // it then stays put until the next read, so idle cycles show no bus churn
    always_comb begin
        nxt_rdata = rdata_ff;
        if (apb_setup) begin
            if (reg_idx == `IDX_FAR_END_CODE) begin
                nxt_rdata = {26'h0, code_ff};
            end else if (reg_idx == `IDX_CODE_IRQ_CTRL) begin
                nxt_rdata = code_ctrl_word;
            end else if (reg_idx == `IDX_LINK_CTRL) begin
                nxt_rdata = link_ctrl_word;
            end else if (in_msg_buf(reg_idx)) begin
                nxt_rdata = {24'h0,
                    msg_buf[`MSG_PTR_W'(reg_idx - `IDX_MSG_BUF_FIRST)]};
            end else begin
                nxt_rdata = 32'h0;
            end
        end
    end

    // read data register
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_ff <= 32'h0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
endmodule

// ### verif/rx_alarm_msg_properties.sv
`include "rx_alarm_defs.svh"

module rx_alarm_msg_properties
    import rx_alarm_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        ARST_N_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [31:0] PRDATA_O,
    // message end and outputs
    input  wire logic        MSG_END_I,
    input  wire logic        INT_N_O,
    input  wire logic        RX_LINK_MSG_EN_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);

    logic [2:0] en_ff;
    logic [2:0] nxt_en;
    logic       wr_acc;

    // shadow of the enables: valid en, removed en, message irq en
    assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    always_comb begin
        nxt_en = en_ff;
        if (wr_acc && PADDR_I[10:2] == `IDX_CODE_IRQ_CTRL) begin
            nxt_en[1:0] = {PWDATA_I[3], PWDATA_I[1]};
        end
        if (wr_acc && PADDR_I[10:2] == `IDX_LINK_CTRL) begin
            nxt_en[2] = PWDATA_I[1];
        end
    end
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            en_ff <= 3'h0;
        end else begin
            en_ff <= nxt_en;
        end
    end

    // read data already stands in the access cycle in which the master takes it
    sequence rd_of(logic [8:0] idx);
        PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I[10:2] == idx;
    endsequence
    sequence msg_done;
        MSG_END_I && RX_LINK_MSG_EN_O && en_ff[2];
    endsequence

    a_quiet_no_en: assert property (en_ff == 3'h0 |-> INT_N_O)
        else $error("request low with every enable off");
    a_msg_raise: assert property (msg_done |-> ##[1:2] !INT_N_O)
        else $error("message end did not pull the request low");
    a_link_en_wr: assert property (wr_acc && PADDR_I[10:2] == `IDX_LINK_CTRL
        |=> RX_LINK_MSG_EN_O == $past(PWDATA_I[2])) else $error("link enable not written");
    a_code_width: assert property (rd_of(`IDX_FAR_END_CODE) |-> PRDATA_O[31:6] == 26'h0)
        else $error("code register wider than six bits");
    a_rm_en_read: assert property (rd_of(`IDX_CODE_IRQ_CTRL) |-> PRDATA_O[3] == en_ff[1])
        else $error("removal enable reads back wrong");
    a_status_layout: assert property (rd_of(`IDX_CODE_IRQ_CTRL)
        |-> PRDATA_O[1] == en_ff[0] && PRDATA_O[31:5] == 27'h0) else $error("code status layout");
    a_msg_en_read: assert property (rd_of(`IDX_LINK_CTRL)
        |-> PRDATA_O[1] == en_ff[2] && PRDATA_O[2] == RX_LINK_MSG_EN_O)
        else $error("link control reads back wrong");
    a_beyond_buf: assert property (PSEL_I && PENABLE_I && !PWRITE_I
        && PADDR_I[10:2] > `IDX_MSG_BUF_LAST |-> PRDATA_O == 32'h0)
        else $error("read past the buffer not zero");
endmodule

bind rx_alarm_msg_interrupts rx_alarm_msg_properties u_props (
    .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .MSG_END_I(MSG_END_I), .INT_N_O(INT_N_O), .RX_LINK_MSG_EN_O(RX_LINK_MSG_EN_O));

// ### verif/tb.sv
`include "rx_alarm_defs.svh"

module tb
    import rx_alarm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_CODE = {1'b0, `IDX_FAR_END_CODE, 2'b00};
    localparam logic [11:0] A_CIRQ = {1'b0, `IDX_CODE_IRQ_CTRL, 2'b00};
    localparam logic [11:0] A_LINK = {1'b0, `IDX_LINK_CTRL, 2'b00};
    localparam logic [11:0] A_BUF  = {1'b0, `IDX_MSG_BUF_FIRST, 2'b00};

    logic        MCLK_I, ARST_N_I, PSEL_I, PENABLE_I, PWRITE_I;
    logic        CODE_STB_I, MSG_BYTE_STB_I, MSG_END_I;
    logic        PREADY_O, PSLVERR_O, INT_N_O, RX_LINK_MSG_EN_O;
    logic [11:0] PADDR_I;
    logic [31:0] PWDATA_I, PRDATA_O;
    logic [5:0]  CODE_I;
    logic [7:0]  MSG_BYTE_I;
    int          miscompares = 0;
    int          num_checks = 0;

    rx_alarm_msg_interrupts u_dut (
        .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
        .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
        .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CODE_STB_I(CODE_STB_I), .CODE_I(CODE_I),
        .MSG_BYTE_STB_I(MSG_BYTE_STB_I), .MSG_BYTE_I(MSG_BYTE_I), .MSG_END_I(MSG_END_I),
        .INT_N_O(INT_N_O), .RX_LINK_MSG_EN_O(RX_LINK_MSG_EN_O));

    // 25 MHz system clock
    initial begin
        MCLK_I = 1'b0;
        forever #20 MCLK_I = ~MCLK_I;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; read data and the error flag are taken at the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat);
        int n;
        PSEL_I <= 1'b1;
        PWRITE_I <= wr;
        PADDR_I <= a;
        PWDATA_I <= wd;
        @(posedge MCLK_I);
        PENABLE_I <= 1'b1;
        n = 0;
        do begin
            @(posedge MCLK_I);
            n++;
        end while (PREADY_O !== 1'b1 && n < 20);
        rdat = PRDATA_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
        if (PREADY_O !== 1'b1) begin
            miscompares++;
            $display("BAD %0t no ready", $time);
            close_out();
        end
        chk({31'h0, PSLVERR_O}, 32'h0, "error response");
        @(posedge MCLK_I);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        apb(1'b0, a, 32'h0, x);
        chk(x, exp, "read");
    endtask

    task automatic irq(input logic exp);
        chk({31'h0, INT_N_O}, {31'h0, exp}, "irq");
    endtask

    // extra edges at the end let the flag and request settle before a check
    task automatic codes(input logic [5:0] c, input int n);
        repeat (n) begin
            CODE_STB_I <= 1'b1;
            CODE_I <= c;
            @(posedge MCLK_I);
        end
        CODE_STB_I <= 1'b0;
        repeat (3) @(posedge MCLK_I);
    endtask

    task automatic msg(input logic [7:0] b0, input int n);
        for (int k = 0; k < n; k++) begin
            MSG_BYTE_STB_I <= 1'b1;
            MSG_BYTE_I <= b0 + 8'(k);
            @(posedge MCLK_I);
        end
        MSG_BYTE_STB_I <= 1'b0;
        MSG_END_I <= 1'b1;
        @(posedge MCLK_I);
        MSG_END_I <= 1'b0;
        repeat (3) @(posedge MCLK_I);
    endtask

    initial begin
        {ARST_N_I, PSEL_I, PENABLE_I, PWRITE_I, CODE_STB_I, MSG_BYTE_STB_I, MSG_END_I} = '0;
        PADDR_I = 12'h000;
        PWDATA_I = 32'h0;
        CODE_I = 6'h00;
        MSG_BYTE_I = 8'h00;
        repeat (12) @(posedge MCLK_I);
        ARST_N_I <= 1'b1;
        @(posedge MCLK_I);
        rd(A_CODE, 32'h0);
        rd(A_CIRQ, 32'h0);
        rd(A_LINK, 32'h0);
        irq(1'b1);
        $display("test reset done");
        // seven votes are one short; two mismatches are one short
        wr(A_CIRQ, 32'h08);
        codes(6'h2A, 7);
        rd(A_CODE, 32'h0);
        codes(6'h2A, 1);
        rd(A_CODE, 32'h2A);
        rd(A_CIRQ, 32'h18);
        codes(6'h15, 2);
        irq(1'b1);
        codes(6'h15, 1);
        irq(1'b0);
        rd(A_CIRQ, 32'h0C);
        rd(A_CODE, 32'h0);
        rd(A_CIRQ, 32'h08);
        irq(1'b1);
        $display("test removal done");
        // validation enabled, removal disabled
        wr(A_CIRQ, 32'h02);
        codes(6'h2A, 8);
        irq(1'b0);
        rd(A_CIRQ, 32'h13);
        rd(A_CIRQ, 32'h12);
        wr(A_CIRQ, 32'h00);
        codes(6'h15, 3);
        irq(1'b1);
        rd(A_CIRQ, 32'h00);
        rd(A_CODE, 32'h0);
        $display("test enables done");
        wr(A_LINK, 32'h06);
        msg(8'hC1, 3);
        irq(1'b0);
        rd(A_LINK, 32'h07);
        for (int k = 0; k < 3; k++) begin
            rd(A_BUF + 12'(4 * k), {24'h0, 8'hC1 + 8'(k)});
        end
        rd(A_LINK, 32'h06);
        irq(1'b1);
        wr(A_LINK, 32'h04);
        msg(8'h50, 2);
        irq(1'b1);
        rd(A_LINK, 32'h04);
        rd(A_BUF, 32'h50);
        wr(A_LINK, 32'h00);
        msg(8'h77, 1);
        rd(A_BUF, 32'h50);
        $display("test message done");
        // read-only and unmapped places
        wr(A_CODE, 32'hFF);
        rd(A_CODE, 32'h0);
        wr(12'h000, 32'hFF);
        rd(12'h000, 32'h0);
        rd(12'h4D8, 32'h0);
        $display("test map done");
        close_out();
    end
endmodule
